// ===== pkg/hbnl_map.svh
// Register offsets, control bit positions and reset values of the breakpoint logic.
// Assumes a byte-wide register window decoded from a 4-bit offset.
`ifndef HBNL_MAP_SVH
`define HBNL_MAP_SVH
`define HBNL_OFF_ADDR0      4'h0
`define HBNL_OFF_ADDR1      4'h1
`define HBNL_OFF_ADDR2      4'h2
`define HBNL_OFF_ADDR3      4'h3
`define HBNL_OFF_DATA0      4'h4
`define HBNL_OFF_CTRL       4'hF
`define HBNL_BIT_ARM        0
`define HBNL_BIT_DIR        1
`define HBNL_BIT_CMP_EN     2
`define HBNL_BIT_MATCH      3
`define HBNL_BIT_HIT        7
`define HBNL_RST_BYTE       8'h00
`define HBNL_CTRL_WMASK     8'h0F
`endif

// ===== pkg/hbnl_pkg.sv
// Types shared by the breakpoint and interrupt merge logic.
// Assumes nothing of its surroundings.
package hbnl_pkg;
    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
        logic [7:0]  data;
        logic        read;
    } hbnl_bus_t;

    typedef struct packed {
        logic       hit;
        logic       match;
        logic       cmp_en;
        logic       dir;
        logic       arm;
    } hbnl_ctrl_t;
endpackage

// ===== design/hbnl_core.sv
// Hardware breakpoint, status register and interrupt merge for a debug port.
// Assumes processor bus signals are synchronous to ref_clk_i; pin inputs are synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "hbnl_map.svh"

module hbnl_core
    import hbnl_pkg::*;
#(
    parameter bit HAS_DATA_CMP = 1'b1
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire hbnl_bus_t  cpu_bus_i,
    input  wire logic       reg_sel_i,
    input  wire logic       reg_wr_i,
    input  wire logic [3:0] reg_off_i,
    input  wire logic [7:0] reg_wdata_i,
    output var  logic [7:0] reg_rdata_o,
    input  wire logic       host_nmi_request_n_i,
    input  wire logic       target_nmi_in_n_i,
    input  wire logic       target_irq_in_n_i,
    input  wire logic       periph_irq_n_i,
    input  wire logic       ready_drive_out_i,
    input  wire logic       target_mode_i,
    input  wire logic       abort_in_n_i,
    input  wire logic       bus_enable_i,
    output var  logic       cpu_nmi_n_o,
    output var  logic       cpu_irq_n_o,
    output var  logic       ready_pullup_en_o,
    output var  logic       cpu_abort_n_o,
    output var  logic       cpu_bus_enable_o,
    output var  logic       breakpoint_trigger_n_o
);
    // Pins from outside: host NMI, target NMI, target IRQ, peripheral IRQ, abort, bus enable, target mode.
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign pin_raw = {target_mode_i, bus_enable_i, abort_in_n_i, periph_irq_n_i,
                      target_irq_in_n_i, target_nmi_in_n_i, host_nmi_request_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sync1_reg[gi] <= 1'b1;
                    sync2_reg[gi] <= 1'b1;
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    logic host_nmi_n;
    logic tgt_nmi_n;
    logic tgt_irq_n;
    logic per_irq_n;
    logic abort_s;
    logic be_s;
    logic tmode_s;
    assign host_nmi_n = sync2_reg[0];
    assign tgt_nmi_n  = sync2_reg[1];
    assign tgt_irq_n  = sync2_reg[2];
    assign per_irq_n  = sync2_reg[3];
    assign abort_s    = sync2_reg[4];
    assign be_s       = sync2_reg[5];
    assign tmode_s    = sync2_reg[6];

    logic [7:0] addr0_reg, addr0_next;
    logic [7:0] addr1_reg, addr1_next;
    logic [7:0] addr2_reg, addr2_next;
    logic [7:0] data0_reg, data0_next;
    hbnl_ctrl_t ctrl_reg, ctrl_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       nmi_n_reg, nmi_n_next;
    logic       irq_n_reg, irq_n_next;
    logic       pull_reg, pull_next;
    logic       abort_reg, abort_next;
    logic       be_reg, be_next;
    logic       trig_n_reg, trig_n_next;

    logic hit;
    logic data_ok;
    logic ctrl_wr;
    logic [7:0] ctrl_byte;

    assign ctrl_byte = {ctrl_reg.hit, 3'h0, ctrl_reg.match, ctrl_reg.cmp_en, ctrl_reg.dir, ctrl_reg.arm};
    assign ctrl_wr   = reg_sel_i && reg_wr_i && (reg_off_i == `HBNL_OFF_CTRL);

    // The 16-bit variant has no comparator, so an enabled compare is simply ignored there.
    always_comb begin
        data_ok = 1'b1;
        if (HAS_DATA_CMP && ctrl_reg.cmp_en) begin
            data_ok = ((cpu_bus_i.data == data0_reg) == ctrl_reg.match);
        end
    end

    // The NMI is raised after the access completes, so the core stops one instruction late.
    assign hit = cpu_bus_i.valid && ctrl_reg.arm
              && (cpu_bus_i.addr == {addr2_reg, addr1_reg, addr0_reg})
              && (cpu_bus_i.read == ctrl_reg.dir) && data_ok;

    always_comb begin
        addr0_next = addr0_reg;
        addr1_next = addr1_reg;
        addr2_next = addr2_reg;
        data0_next = data0_reg;
        ctrl_next  = ctrl_reg;
        if (reg_sel_i && reg_wr_i) begin
            if (reg_off_i == `HBNL_OFF_ADDR0) begin
                addr0_next = reg_wdata_i;
            end else if (reg_off_i == `HBNL_OFF_ADDR1) begin
                addr1_next = reg_wdata_i;
            end else if (reg_off_i == `HBNL_OFF_ADDR2) begin
                addr2_next = reg_wdata_i;
            end else if (reg_off_i == `HBNL_OFF_DATA0) begin
                data0_next = reg_wdata_i;
            end else if (reg_off_i == `HBNL_OFF_CTRL) begin
                ctrl_next.arm    = reg_wdata_i[`HBNL_BIT_ARM];
                ctrl_next.dir    = reg_wdata_i[`HBNL_BIT_DIR];
                ctrl_next.cmp_en = reg_wdata_i[`HBNL_BIT_CMP_EN];
                ctrl_next.match  = reg_wdata_i[`HBNL_BIT_MATCH];
            end
        end
        // A hit in the same cycle as the clearing write wins, so no breakpoint is lost.
        if (hit) begin
            ctrl_next.hit = 1'b1;
        end else if (ctrl_wr && !reg_wdata_i[`HBNL_BIT_HIT]) begin
            ctrl_next.hit = 1'b0;
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        if (reg_sel_i) begin
            if (reg_off_i == `HBNL_OFF_ADDR0) begin
                rdata_next = addr0_reg;
            end else if (reg_off_i == `HBNL_OFF_ADDR1) begin
                rdata_next = addr1_reg;
            end else if (reg_off_i == `HBNL_OFF_ADDR2) begin
                rdata_next = addr2_reg;
            end else if (reg_off_i == `HBNL_OFF_DATA0) begin
                rdata_next = data0_reg;
            end else if (reg_off_i == `HBNL_OFF_CTRL) begin
                rdata_next = ctrl_byte;
            end
        end
    end

    always_comb begin
        nmi_n_next  = host_nmi_n && !hit && tgt_nmi_n;
        trig_n_next = !hit;
        irq_n_next  = tgt_irq_n && per_irq_n;
        pull_next   = ready_drive_out_i;
        abort_next  = tmode_s ? abort_s : 1'b1;
        be_next     = tmode_s ? be_s : 1'b1;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr0_reg  <= `HBNL_RST_BYTE;
            addr1_reg  <= `HBNL_RST_BYTE;
            addr2_reg  <= `HBNL_RST_BYTE;
            data0_reg  <= `HBNL_RST_BYTE;
            ctrl_reg   <= '0;
            rdata_reg  <= `HBNL_RST_BYTE;
            nmi_n_reg  <= 1'b1;
            irq_n_reg  <= 1'b1;
            pull_reg   <= 1'b1;
            abort_reg  <= 1'b1;
            be_reg     <= 1'b1;
            trig_n_reg <= 1'b1;
        end else begin
            addr0_reg  <= addr0_next;
            addr1_reg  <= addr1_next;
            addr2_reg  <= addr2_next;
            data0_reg  <= data0_next;
            ctrl_reg   <= ctrl_next;
            rdata_reg  <= rdata_next;
            nmi_n_reg  <= nmi_n_next;
            irq_n_reg  <= irq_n_next;
            pull_reg   <= pull_next;
            abort_reg  <= abort_next;
            be_reg     <= be_next;
            trig_n_reg <= trig_n_next;
        end
    end

    assign reg_rdata_o            = rdata_reg;
    assign cpu_nmi_n_o            = nmi_n_reg;
    assign cpu_irq_n_o            = irq_n_reg;
    assign ready_pullup_en_o      = pull_reg;
    assign cpu_abort_n_o          = abort_reg;
    assign cpu_bus_enable_o       = be_reg;
    assign breakpoint_trigger_n_o = trig_n_reg;
endmodule
`default_nettype wire

// ===== verif/hbnl_core_properties.sv
// Port timing properties of the breakpoint and interrupt merge block.
// Assumes pins change a few ns after the clock edge.
`timescale 1ns/100ps
`default_nettype none
module hbnl_core_properties
    import hbnl_pkg::*;
(
    input wire logic      ref_clk_i,
    input wire logic      rst_n_i,
    input wire hbnl_bus_t cpu_bus_i,
    input wire logic      host_nmi_request_n_i,
    input wire logic      target_nmi_in_n_i,
    input wire logic      target_irq_in_n_i,
    input wire logic      ready_drive_out_i,
    input wire logic      target_mode_i,
    input wire logic      cpu_nmi_n_o,
    input wire logic      cpu_irq_n_o,
    input wire logic      ready_pullup_en_o,
    input wire logic      cpu_abort_n_o,
    input wire logic      cpu_bus_enable_o,
    input wire logic      breakpoint_trigger_n_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_trig_idle_bus: assert property (!cpu_bus_i.valid |=> breakpoint_trigger_n_o)
        else $error("trigger without bus cycle");
    chk_nmi_with_trig: assert property (!breakpoint_trigger_n_o |-> !cpu_nmi_n_o)
        else $error("trigger without nmi");
    chk_nmi_quiet: assert property ((host_nmi_request_n_i && target_nmi_in_n_i)[*4] ##0 !cpu_bus_i.valid
        |=> cpu_nmi_n_o) else $error("nmi without source");
    chk_host_nmi: assert property ((!host_nmi_request_n_i)[*4] |-> !cpu_nmi_n_o)
        else $error("host nmi lost");
    chk_target_nmi: assert property ((!target_nmi_in_n_i)[*4] |-> !cpu_nmi_n_o)
        else $error("target nmi lost");
    chk_target_irq: assert property ((!target_irq_in_n_i)[*4] |-> !cpu_irq_n_o)
        else $error("target irq lost");
    chk_ready_gate: assert property (1 |=> ready_pullup_en_o == $past(ready_drive_out_i))
        else $error("pull-up gate wrong");
    chk_abort_default: assert property ((!target_mode_i)[*4] |-> cpu_abort_n_o && cpu_bus_enable_o)
        else $error("abort or bus enable not held");
endmodule
bind hbnl_core hbnl_core_properties chk (.*);
`default_nettype wire

// ===== verif/hbnl_cpu_model.sv
// Processor bus model: one bus cycle per call.
// Assumes the caller runs at a clock edge plus a small delay.
`timescale 1ns/100ps
`default_nettype none
module hbnl_cpu_model
    import hbnl_pkg::*;
(
    input  wire logic      ref_clk_i,
    output var  hbnl_bus_t bus_o
);
    initial bus_o = '0;
    task automatic cycle(input logic [23:0] a, input logic [7:0] d, input logic rd);
        @(posedge ref_clk_i) #5;
        bus_o = '{1'b1, a, d, rd};
        @(posedge ref_clk_i) #5;
        // Idle cycles show inverted values so logic that ignores valid is caught.
        bus_o = '{1'b0, ~a, ~d, ~rd};
    endtask
endmodule
`default_nettype wire

// ===== verif/hbnl_core_test.sv
// Self-checking bench: register port, breakpoint hits, pin merging.
// Assumes the bus model drives the processor bus.
`timescale 1ns/100ps
`default_nettype none
`include "hbnl_map.svh"
module hbnl_core_test
    import hbnl_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, sel = 1'b0, wr = 1'b0, rdy = 1'b1, mode = 1'b0;
    logic [3:0]  off = 4'h0, pins = 4'hF;
    logic [7:0]  wdata = 8'h00, rdata, exp, got;
    logic [1:0]  ab = 2'b11;
    hbnl_bus_t   bus;
    logic        nmi, irq, pull, abort_n, be, trig;
    int          n_fail = 0, checks = 0;
    logic [7:0]  tc [10] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h0F, 8'h0F, 8'h07, 8'h07, 8'h02, 8'h03};
    logic [23:0] ta [10] = '{24'h3000, 24'h3000, 24'h3001, 24'h3000, 24'h3000, 24'h3000, 24'h3000,
                             24'h3000, 24'h3000, 24'h13000};
    logic [9:0]  td = 10'b0001100000, tr = 10'b1111111101, th = 10'b0001011010;
    always #50 clk = ~clk;
    hbnl_cpu_model cpu (.ref_clk_i(clk), .bus_o(bus));
    hbnl_core uut (.ref_clk_i(clk), .rst_n_i(rst_n), .cpu_bus_i(bus), .reg_sel_i(sel), .reg_wr_i(wr),
        .reg_off_i(off), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .host_nmi_request_n_i(pins[0]),
        .target_nmi_in_n_i(pins[1]), .target_irq_in_n_i(pins[2]), .periph_irq_n_i(pins[3]),
        .ready_drive_out_i(rdy), .target_mode_i(mode), .abort_in_n_i(ab[1]), .bus_enable_i(ab[0]),
        .cpu_nmi_n_o(nmi), .cpu_irq_n_o(irq), .ready_pullup_en_o(pull), .cpu_abort_n_o(abort_n),
        .cpu_bus_enable_o(be), .breakpoint_trigger_n_o(trig));
    task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
        checks++;
        if (got !== want) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] o, input logic [7:0] d);
        sel = 1'b1;
        wr = w;
        off = o;
        wdata = d;
        @(posedge clk) #5;
        got = rdata;
        sel = 1'b0;
        wr = 1'b0;
        // One idle edge keeps back-to-back calls from toggling the strobe in one time step.
        @(posedge clk) #5;
    endtask
    task automatic rd(input logic [3:0] o, input logic [7:0] e);
        acc(1'b0, o, 8'h00);
        check(got, e, "read");
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        stop_test;
    end
    initial begin
        repeat (12) @(posedge clk);
        #5 rst_n = 1'b1;
        for (int i = 0; i < 16; i++) begin
            rd(i[3:0], 8'h00);
            acc(1'b1, i[3:0], 8'hFF);
            exp = (i < 3 || i == 4) ? 8'hFF : (i == 15 ? 8'h0F : 8'h00);
            rd(i[3:0], exp);
        end
        acc(1'b1, `HBNL_OFF_ADDR0, 8'h00);
        acc(1'b1, `HBNL_OFF_ADDR1, 8'h30);
        acc(1'b1, `HBNL_OFF_ADDR2, 8'h00);
        acc(1'b1, `HBNL_OFF_DATA0, 8'h55);
        $display("test registers done");
        for (int i = 0; i < 10; i++) begin
            acc(1'b1, `HBNL_OFF_CTRL, tc[i]);
            cpu.cycle(ta[i], {7'h2A, !td[i]}, tr[i]);
            check({6'h0, nmi, trig}, {6'h0, !th[i], !th[i]}, "hit pulse");
            @(posedge clk) #5;
            check({6'h0, nmi, trig}, 8'h03, "pulse end");
            rd(`HBNL_OFF_CTRL, {th[i], 3'h0, tc[i][3:0]});
        end
        cpu.cycle(24'h003000, 8'h55, 1'b1);
        cpu.cycle(24'h000000, 8'h55, 1'b1);
        acc(1'b1, `HBNL_OFF_CTRL, 8'h83);
        rd(`HBNL_OFF_CTRL, 8'h83);
        acc(1'b1, `HBNL_OFF_CTRL, 8'h03);
        rd(`HBNL_OFF_CTRL, 8'h03);
        $display("test breakpoint done");
        for (int i = 0; i < 5; i++) begin
            pins = (i == 4) ? 4'hF : ~(4'h1 << i);
            repeat (4) @(posedge clk) #5;
            check({6'h0, nmi, irq}, {6'h0, i > 1, i < 2 || i == 4}, "merge");
        end
        rdy = 1'b0;
        ab = 2'b00;
        repeat (4) @(posedge clk) #5;
        check({5'h0, pull, abort_n, be}, 8'h03, "stand-alone");
        mode = 1'b1;
        repeat (4) @(posedge clk) #5;
        check({5'h0, pull, abort_n, be}, 8'h00, "target mode");
        $display("test pins done");
        stop_test;
    end
endmodule
`default_nettype wire
